// ==== core/ppd_pkg.sv ====
// constants, layouts and selector type for the parallel port register decode
// assumes one 8-bit register per APB word, index times four is the byte
package ppd_pkg;
  // runtime first-level offsets, kept as word indices
  localparam logic [15:0] RT_DATA = 16'h0000;
  localparam logic [15:0] RT_STATUS = 16'h0001;
  localparam logic [15:0] RT_CONTROL = 16'h0002;
  localparam logic [15:0] RT_EPP_ADDR = 16'h0003;
  localparam logic [15:0] RT_EPP_D0 = 16'h0004;
  localparam logic [15:0] RT_EPP_D3 = 16'h0007;
  localparam logic [15:0] RT_FIFO = 16'h0400;
  localparam logic [15:0] RT_CAP_B = 16'h0401;
  localparam logic [15:0] RT_MODE = 16'h0402;
  localparam logic [15:0] RT_EXT_INDEX = 16'h0403;
  localparam logic [15:0] RT_EXT_DATA = 16'h0404;
  localparam logic [15:0] RT_EXT_AUX = 16'h0405;
  // second-level offsets
  localparam logic [7:0] XL_CTL0 = 8'h00;
  localparam logic [7:0] XL_CTL2 = 8'h02;
  localparam logic [7:0] XL_CTL4 = 8'h04;
  localparam logic [7:0] XL_SETUP = 8'h05;
  localparam logic [7:0] XL_RESET = 8'h00;
  // configuration indices
  localparam logic [7:0] CF_ACTIVATE = 8'h30;
  localparam logic [7:0] CF_BASE_HIGH = 8'h60;
  localparam logic [7:0] CF_BASE_LOW = 8'h61;
  localparam logic [7:0] CF_IRQ_SEL = 8'h70;
  localparam logic [7:0] CF_IRQ_KIND = 8'h71;
  localparam logic [7:0] CF_DMA_SEL = 8'h74;
  localparam logic [7:0] CF_DMA2 = 8'h75;
  localparam logic [7:0] CF_OPTIONS = 8'hF0;
  // configuration reset values
  localparam logic [7:0] RST_ACTIVATE = 8'h00;
  localparam logic [7:0] RST_BASE_HIGH = 8'h02;
  localparam logic [7:0] RST_BASE_LOW = 8'h78;
  localparam logic [7:0] RST_IRQ_SEL = 8'h07;
  localparam logic [7:0] RST_IRQ_KIND = 8'h02;
  localparam logic [7:0] RST_DMA_SEL = 8'h04;
  localparam logic [7:0] VAL_DMA2 = 8'h04;
  localparam logic [7:0] RST_OPTIONS = 8'hF2;
  localparam logic [7:0] RST_RT = 8'h00;
  // writable-bit masks
  localparam logic [7:0] MSK_BASE_HIGH = 8'h07;
  localparam logic [7:0] MSK_BASE_LOW = 8'hFC;
  localparam logic [7:0] MSK_IRQ_KIND = 8'h02;
  // field positions
  localparam int OPT_EXT_BIT = 4;
  localparam int ACT_BIT = 0;
  localparam int KIND_LEVEL_BIT = 0;
  localparam int MODE_LSB = 5;
  // mode codes
  localparam logic [2:0] MD_STD = 3'h0;
  localparam logic [2:0] MD_BIDIR = 3'h1;
  localparam logic [2:0] MD_FIFO = 3'h2;
  localparam logic [2:0] MD_ECP = 3'h3;
  localparam logic [2:0] MD_EPP = 3'h4;
  localparam logic [2:0] MD_TEST = 3'h6;
  localparam logic [2:0] MD_CAP = 3'h7;
  // APB region select, paddr bits 19:18
  localparam logic [1:0] RG_RUNTIME = 2'h0;
  localparam logic [1:0] RG_CONFIG = 2'h1;
  localparam logic [7:0] RD_ZERO = 8'h00;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_DATA, SEL_ECP_ADDRESS_FIFO_IN, SEL_STATUS, SEL_CONTROL, SEL_EPP_ADDR,
    SEL_EPP_DATA, SEL_STD_FIFO, SEL_ECP_FIFO, SEL_TEST_FIFO, SEL_CAP_A,
    SEL_CAP_B, SEL_MODE, SEL_EXT_INDEX, SEL_EXT_DATA, SEL_EXT_AUX
  } ppd_sel_t;

  typedef enum logic {ST_IDLE, ST_ANSWER} ppd_state_t;
endpackage

// ==== core/ppd_sel_if.sv ====
// carries mode, offset and extended-access enable to the runtime decoder
// assumes ppd_pkg compiled first
`timescale 1ns/10ps
`default_nettype none
interface ppd_sel_if;
  import ppd_pkg::*;
  logic [2:0] mode;
  logic [15:0] offset;
  logic ext_en;
  ppd_sel_t sel;
  modport dec (input mode, input offset, input ext_en, output sel);
  modport user (output mode, output offset, output ext_en, input sel);
endinterface
`default_nettype wire

// ==== core/ppd_rt_decode.sv ====
// runtime register selector: offset and mode to register
// assumes offset is already relative to the port base
`timescale 1ns/10ps
`default_nettype none
module ppd_rt_decode
  import ppd_pkg::*;
(
  ppd_sel_if.dec bus
);
  always_comb begin
    bus.sel = SEL_NONE;
    if (bus.offset == RT_DATA) begin
      if (bus.mode == MD_STD || bus.mode == MD_BIDIR) begin
        bus.sel = SEL_DATA;
      end else if (bus.mode == MD_ECP) begin
        bus.sel = SEL_ECP_ADDRESS_FIFO_IN;
      end else if (bus.mode == MD_EPP) begin
        bus.sel = SEL_DATA;
      end
    end else if (bus.offset == RT_STATUS || bus.offset == RT_CONTROL) begin
      if (bus.mode <= MD_EPP) begin
        bus.sel = (bus.offset == RT_STATUS) ? SEL_STATUS : SEL_CONTROL;
      end
    end else if (bus.offset == RT_EPP_ADDR) begin
      if (bus.mode == MD_EPP) begin
        bus.sel = SEL_EPP_ADDR;
      end
    end else if (bus.offset >= RT_EPP_D0 && bus.offset <= RT_EPP_D3) begin
      if (bus.mode == MD_EPP) begin
        bus.sel = SEL_EPP_DATA;
      end
    end else if (bus.offset == RT_FIFO) begin
      if (bus.mode == MD_FIFO) begin
        bus.sel = SEL_STD_FIFO;
      end else if (bus.mode == MD_ECP) begin
        bus.sel = SEL_ECP_FIFO;
      end else if (bus.mode == MD_TEST) begin
        bus.sel = SEL_TEST_FIFO;
      end else if (bus.mode == MD_CAP) begin
        bus.sel = SEL_CAP_A;
      end
    end else if (bus.offset == RT_CAP_B) begin
      if (bus.mode == MD_CAP) begin
        bus.sel = SEL_CAP_B;
      end
    end else if (bus.offset == RT_MODE) begin
      bus.sel = SEL_MODE;
    end else if (bus.ext_en && bus.mode <= MD_ECP) begin
      if (bus.offset == RT_EXT_INDEX) begin
        bus.sel = SEL_EXT_INDEX;
      end else if (bus.offset == RT_EXT_DATA) begin
        bus.sel = SEL_EXT_DATA;
      end else if (bus.offset == RT_EXT_AUX) begin
        bus.sel = SEL_EXT_AUX;
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/ppd_ext_bank.sv ====
// four second-level extended registers behind the extended data window
// assumes writes arrive as single-cycle strobes
`timescale 1ns/10ps
`default_nettype none
module ppd_ext_bank
  import ppd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wr_in,
  input wire logic [7:0] idx_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out,
  output logic [31:0] regs_out
);
  localparam logic [7:0] XL_IDX [4] = '{XL_CTL0, XL_CTL2, XL_CTL4, XL_SETUP};
  logic [3:0] hit;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ent
      logic [7:0] val;
      assign hit[g] = (idx_in == XL_IDX[g]);
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          val <= XL_RESET;
        end else if (wr_in && hit[g]) begin
          val <= wdata_in;
        end
      end
      assign regs_out[8*g +: 8] = val;
    end
  endgenerate

  always_comb begin
    rdata_out = RD_ZERO;
    for (int i = 0; i < 4; i++) begin
      if (hit[i]) begin
        rdata_out = regs_out[8*i +: 8];
      end
    end
  end
endmodule
`default_nettype wire

// ==== core/ppd_top.sv ====
// parallel port register decode: APB slave, config bank, runtime map
// assumes APB master on mclk_in; global activation bit comes from outside
`timescale 1ns/10ps
`default_nettype none
module ppd_top
  import ppd_pkg::*;
#(
  parameter logic [7:0] CAP_A_VALUE = 8'h10,
  parameter logic [7:0] CAP_B_VALUE = 8'h00
)(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [19:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic global_cfg_enable_in,
  input wire logic [7:0] port_status_in,
  output logic pp_active_out,
  output logic [2:0] pp_mode_out,
  output logic [7:0] pp_data_out,
  output logic [7:0] pp_control_out,
  output logic irq_level_out,
  output logic [7:0] irq_select_out,
  output logic [7:0] dma_select_out,
  output logic fifo_push_out,
  output logic [7:0] fifo_data_out
);
  ppd_state_t state;
  logic [7:0] activate, base_address_high, base_address_low;
  logic [7:0] irq_select_wake, irq_kind_rw, dma_channel_choice;
  logic [7:0] port_options, mode_control, pp_data_latch, port_control_reg;
  logic [7:0] epp_address_port, ext_index_ptr, ext_aux_state, fifo_last;
  logic [7:0] epp_data [4];
  logic [7:0] next_rdata, ext_rdata;
  logic next_err, ext_mode, rt_hit, cf_hit, wr_fire, queue_wr;
  logic [1:0] region;
  logic [15:0] io_addr, base16;
  logic [7:0] cf_index, wbyte;
  ppd_sel_t sel;
  ppd_sel_if sif ();

  assign region = paddr_in[19:18];
  assign io_addr = paddr_in[17:2];
  assign cf_index = paddr_in[9:2];
  assign wbyte = pwdata_in[7:0];
  assign base16 = {base_address_high, base_address_low};
  // extended ECP: ECP mode with extended access opened
  assign ext_mode = (mode_control[7:MODE_LSB] == MD_ECP) &&
                    port_options[OPT_EXT_BIT];
  // offset from the full 16-bit base; mode then picks the register at that offset
  assign sif.mode = mode_control[7:MODE_LSB];
  assign sif.offset = io_addr - base16;
  assign sif.ext_en = port_options[OPT_EXT_BIT];
  assign sel = pp_active_out ? sif.sel : SEL_NONE;
  assign rt_hit = (region == RG_RUNTIME);
  assign cf_hit = (region == RG_CONFIG) && (paddr_in[17:10] == 8'h00);
  assign wr_fire = (state == ST_ANSWER) && psel_in && penable_in &&
                   pwrite_in && !pslverr_out;
  assign queue_wr = wr_fire && rt_hit &&
                    (sel == SEL_ECP_ADDRESS_FIFO_IN || sel == SEL_STD_FIFO ||
                     sel == SEL_ECP_FIFO || sel == SEL_TEST_FIFO);

  ppd_rt_decode u_dec (
    .bus (sif.dec)
  );

  ppd_ext_bank u_ext (
    .mclk_in (mclk_in),
    .rst_n_in (rst_n_in),
    .wr_in (wr_fire && rt_hit && sel == SEL_EXT_DATA),
    .idx_in (ext_index_ptr),
    .wdata_in (wbyte),
    .rdata_out (ext_rdata),
    .regs_out ()
  );

  // read mux; unmatched runtime reads return zero with no error
  always_comb begin
    next_rdata = RD_ZERO;
    next_err = 1'b0;
    if (rt_hit) begin
      case (sel)
        SEL_DATA: next_rdata = pp_data_latch;
        SEL_STATUS: next_rdata = port_status_in;
        SEL_CONTROL: next_rdata = port_control_reg;
        SEL_EPP_ADDR: next_rdata = epp_address_port;
        SEL_EPP_DATA: next_rdata = epp_data[sif.offset[1:0]];
        SEL_ECP_FIFO: next_rdata = fifo_last;
        SEL_TEST_FIFO: next_rdata = fifo_last;
        SEL_CAP_A: next_rdata = CAP_A_VALUE;
        SEL_CAP_B: next_rdata = CAP_B_VALUE;
        SEL_MODE: next_rdata = mode_control;
        SEL_EXT_INDEX: next_rdata = ext_index_ptr;
        SEL_EXT_DATA: next_rdata = ext_rdata;
        SEL_EXT_AUX: next_rdata = ext_aux_state;
        default: next_rdata = RD_ZERO;
      endcase
    end else if (cf_hit) begin
      if (cf_index == CF_ACTIVATE) begin
        next_rdata = activate;
      end else if (cf_index == CF_BASE_HIGH) begin
        next_rdata = base_address_high;
      end else if (cf_index == CF_BASE_LOW) begin
        next_rdata = base_address_low;
      end else if (cf_index == CF_IRQ_SEL) begin
        next_rdata = irq_select_wake;
      end else if (cf_index == CF_IRQ_KIND) begin
        next_rdata = irq_kind_rw | {7'h00, ext_mode};
      end else if (cf_index == CF_DMA_SEL) begin
        next_rdata = dma_channel_choice;
      end else if (cf_index == CF_DMA2) begin
        next_rdata = VAL_DMA2;
      end else if (cf_index == CF_OPTIONS) begin
        next_rdata = port_options;
      end else begin
        next_err = 1'b1;
      end
    end else begin
      next_err = 1'b1;
    end
  end

  // APB: answer in the first cycle of the access phase
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= ST_IDLE;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (psel_in && !penable_in) begin
            state <= ST_ANSWER;
            pready_out <= 1'b1;
            pslverr_out <= next_err;
            prdata_out <= pwrite_in ? 32'h0000_0000 : {24'h000000, next_rdata};
          end
        end
        default: begin
          state <= ST_IDLE;
          pready_out <= 1'b0;
          pslverr_out <= 1'b0;
        end
      endcase
    end
  end

  // configuration bank
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      activate <= RST_ACTIVATE;
      base_address_high <= RST_BASE_HIGH;
      base_address_low <= RST_BASE_LOW;
      irq_select_wake <= RST_IRQ_SEL;
      irq_kind_rw <= RST_IRQ_KIND;
      dma_channel_choice <= RST_DMA_SEL;
      port_options <= RST_OPTIONS;
    end else if (wr_fire && cf_hit) begin
      if (cf_index == CF_ACTIVATE) begin
        activate <= wbyte;
      end else if (cf_index == CF_BASE_HIGH) begin
        base_address_high <= wbyte & MSK_BASE_HIGH;
      end else if (cf_index == CF_BASE_LOW) begin
        base_address_low <= wbyte & MSK_BASE_LOW;
      end else if (cf_index == CF_IRQ_SEL) begin
        irq_select_wake <= wbyte;
      end else if (cf_index == CF_IRQ_KIND) begin
        irq_kind_rw <= wbyte & MSK_IRQ_KIND;
      end else if (cf_index == CF_DMA_SEL) begin
        dma_channel_choice <= wbyte;
      end else if (cf_index == CF_OPTIONS) begin
        port_options <= wbyte;
      end
    end
  end

  // runtime registers
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_control <= RST_RT;
      pp_data_latch <= RST_RT;
      port_control_reg <= RST_RT;
      epp_address_port <= RST_RT;
      ext_index_ptr <= RST_RT;
      ext_aux_state <= RST_RT;
      for (int i = 0; i < 4; i++) begin
        epp_data[i] <= RST_RT;
      end
    end else if (wr_fire && rt_hit) begin
      case (sel)
        SEL_DATA: pp_data_latch <= wbyte;
        SEL_CONTROL: port_control_reg <= wbyte;
        SEL_EPP_ADDR: epp_address_port <= wbyte;
        SEL_EPP_DATA: epp_data[sif.offset[1:0]] <= wbyte;
        SEL_MODE: mode_control <= wbyte;
        SEL_EXT_INDEX: ext_index_ptr <= wbyte;
        SEL_EXT_AUX: ext_aux_state <= wbyte;
        default: ;
      endcase
    end
  end

  // queue pushes: one strobe and one byte per accepted write to a queue register (address, standard, ECP or test FIFO)
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fifo_push_out <= 1'b0;
      fifo_data_out <= RST_RT;
      fifo_last <= RST_RT;
    end else begin
      fifo_push_out <= queue_wr;
      if (queue_wr) begin
        fifo_last <= wbyte;
        fifo_data_out <= wbyte;
      end
    end
  end

  // registered views toward the port logic
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pp_active_out <= 1'b0;
      pp_mode_out <= MD_STD;
      pp_data_out <= RST_RT;
      pp_control_out <= RST_RT;
      irq_level_out <= 1'b0;
      irq_select_out <= RST_IRQ_SEL;
      dma_select_out <= RST_DMA_SEL;
    end else begin
      pp_active_out <= activate[ACT_BIT] && global_cfg_enable_in;
      pp_mode_out <= mode_control[7:MODE_LSB];
      pp_data_out <= pp_data_latch;
      pp_control_out <= port_control_reg;
      irq_level_out <= ext_mode;
      irq_select_out <= irq_select_wake;
      dma_select_out <= dma_channel_choice;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_pready_one_cycle: assert property (
    pready_out |=> !pready_out)
    else $error("pready held beyond one cycle");
  a_setup_gets_answer: assert property (
    (state == ST_IDLE && psel_in && !penable_in) |=> pready_out)
    else $error("setup not answered next cycle");
  a_base_high_zero: assert property (
    base_address_high[7:3] == 5'h00)
    else $error("base high upper bits not zero");
  a_base_low_zero: assert property (
    base_address_low[1:0] == 2'h0)
    else $error("base low lower bits not zero");
  a_irq_level_mode: assert property (
    ##1 irq_level_out == $past(ext_mode))
    else $error("interrupt kind does not follow mode");
  a_dma2_fixed: assert property (
    (state == ST_IDLE && psel_in && !penable_in && !pwrite_in && cf_hit &&
     cf_index == CF_DMA2) |=> prdata_out[7:0] == VAL_DMA2)
    else $error("second dma report not 04h");
  a_ext_ignored: assert property (
    (wr_fire && rt_hit && !port_options[OPT_EXT_BIT] &&
     sif.offset == RT_EXT_INDEX) |=> $stable(ext_index_ptr))
    else $error("disabled extended index was written");
  a_epp_only_mode4: assert property (
    (sel == SEL_EPP_ADDR || sel == SEL_EPP_DATA) |-> sif.mode == MD_EPP)
    else $error("epp port decoded outside epp mode");
  a_active_gate: assert property (
    pp_active_out |-> $past(activate[ACT_BIT] && global_cfg_enable_in))
    else $error("port active without activation");
  a_push_pulse: assert property (
    fifo_push_out |=> !fifo_push_out)
    else $error("queue push held beyond one cycle");
  a_push_data: assert property (
    queue_wr |=> fifo_push_out && fifo_data_out == $past(wbyte))
    else $error("queue byte not presented with push");
  a_mode_always: assert property (
    (rt_hit && pp_active_out && sif.offset == RT_MODE) |->
    sel == SEL_MODE)
    else $error("mode control not decoded");
  a_ext_needs_bit: assert property (
    (sel == SEL_EXT_INDEX || sel == SEL_EXT_DATA || sel == SEL_EXT_AUX) |->
    port_options[OPT_EXT_BIT])
    else $error("extended register reached while closed");
  a_ext_low_modes: assert property (
    (sel == SEL_EXT_INDEX || sel == SEL_EXT_DATA || sel == SEL_EXT_AUX) |->
    sif.mode <= MD_ECP)
    else $error("extended register decoded in mode above 3");
  a_cap_mode7: assert property (
    (sel == SEL_CAP_A || sel == SEL_CAP_B) |-> sif.mode == MD_CAP)
    else $error("capability view decoded outside mode 7");
  a_kind_follows: assert property (
    (state == ST_IDLE && psel_in && !penable_in && !pwrite_in && cf_hit &&
     cf_index == CF_IRQ_KIND) |=>
    prdata_out[KIND_LEVEL_BIT] == $past(ext_mode))
    else $error("interrupt kind bit 0 not the mode level");
  a_kind_fixed: assert property (
    (irq_kind_rw & ~MSK_IRQ_KIND) == 8'h00)
    else $error("interrupt kind read-only bits written");
  a_inactive_quiet: assert property (
    !pp_active_out |-> sel == SEL_NONE)
    else $error("runtime register decoded while inactive");
  a_runtime_no_err: assert property (
    (state == ST_IDLE && psel_in && !penable_in && rt_hit) |=>
    !pslverr_out)
    else $error("runtime access answered with error");
  a_ignored_zero: assert property (
    (state == ST_IDLE && psel_in && !penable_in && !pwrite_in && rt_hit &&
     sel == SEL_NONE) |=> prdata_out == 32'h0000_0000)
    else $error("ignored runtime read not zero");
  a_status_view: assert property (
    (state == ST_IDLE && psel_in && !penable_in && !pwrite_in && rt_hit &&
     sel == SEL_STATUS) |=> prdata_out[7:0] == $past(port_status_in))
    else $error("status read does not show port status");
  a_mode_view: assert property (
    ##1 pp_mode_out == $past(mode_control[7:MODE_LSB]))
    else $error("mode view does not follow mode control");
  a_data_view: assert property (
    ##1 pp_data_out == $past(pp_data_latch))
    else $error("data view does not follow data latch");
endmodule
`default_nettype wire

// ==== verif/parallel_port_register_decode_test.sv ====
// self-checking bench for the parallel port register decode over APB
// assumes ppd_pkg and the core files are compiled first
`timescale 1ns/10ps
`default_nettype none
module parallel_port_register_decode_test;
  import ppd_pkg::*;
  typedef struct {logic wr; logic [7:0] rd; logic err;} ppd_exp_t;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [19:0] paddr_in = 20'h00000;
  logic [31:0] pwdata_in = 32'h00000000;
  logic global_cfg_enable_in = 1'b0;
  logic [7:0] port_status_in = 8'h00;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, pp_active_out, irq_level_out, fifo_push_out;
  logic [2:0] pp_mode_out;
  logic [7:0] pp_data_out, pp_control_out, irq_select_out, dma_select_out;
  logic [7:0] fifo_data_out;
  ppd_exp_t exp_q[$];
  ppd_exp_t e;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  int push_n = 0;
  int seed = 32'hbfa0;
  logic [7:0] d, st, ci[8], cv[8], xi[4];

  ppd_top dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .global_cfg_enable_in(global_cfg_enable_in),
    .port_status_in(port_status_in), .pp_active_out(pp_active_out),
    .pp_mode_out(pp_mode_out), .pp_data_out(pp_data_out),
    .pp_control_out(pp_control_out), .irq_level_out(irq_level_out),
    .irq_select_out(irq_select_out), .dma_select_out(dma_select_out),
    .fifo_push_out(fifo_push_out), .fifo_data_out(fifo_data_out));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // result watcher: oldest note against each answer
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
    if (fifo_push_out === 1'b1) push_n++;
    if (pready_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected answer", 32'h1, 32'h0);
      end else begin
        e = exp_q.pop_front();
        check("pslverr", {31'h0, pslverr_out}, {31'h0, e.err});
        if (!e.wr) check("prdata", prdata_out, {24'h0, e.rd});
      end
    end
  end

  // one APB transfer, entered right after a rising edge
  task automatic xfer(input logic w, input logic [19:0] a,
                      input logic [7:0] wd, input logic [7:0] rd,
                      input logic err);
    int n;
    n = 0;
    exp_q.push_back('{w, rd, err});
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {$random(seed) & 32'hFFFFFF00} | {24'h0, wd};
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      end_of_test();
    end
  endtask

  task automatic idle(input int c);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    repeat (c) @(posedge mclk_in);
  endtask

  function automatic logic [19:0] ca(input logic [7:0] i);
    return 20'h40000 | {10'h0, i, 2'b00};
  endfunction

  function automatic logic [19:0] ra(input logic [15:0] k);
    return {2'b00, 16'h0278 + k, 2'b00};
  endfunction

  task automatic cw(input logic [7:0] i, input logic [7:0] v);
    xfer(1'b1, ca(i), v, 8'h00, 1'b0);
  endtask
  task automatic cr(input logic [7:0] i, input logic [7:0] v);
    xfer(1'b0, ca(i), 8'h00, v, 1'b0);
  endtask
  task automatic rw(input logic [15:0] k, input logic [7:0] v);
    xfer(1'b1, ra(k), v, 8'h00, 1'b0);
  endtask
  task automatic rr(input logic [15:0] k, input logic [7:0] v);
    xfer(1'b0, ra(k), 8'h00, v, 1'b0);
  endtask
  task automatic mode(input logic [2:0] m);
    rw(RT_MODE, {m, 5'h00});
  endtask

  initial begin
    ci = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75, 8'hF0};
    cv = '{8'h00, 8'h02, 8'h78, 8'h07, 8'h02, 8'h04, 8'h04, 8'hF2};
    xi = '{8'h00, 8'h02, 8'h04, 8'h05};
    repeat (10) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    for (int i = 0; i < 8; i++) cr(ci[i], cv[i]);
    idle(1);
    check("irq_select", {24'h0, irq_select_out}, 32'h07);
    check("dma_select", {24'h0, dma_select_out}, 32'h04);
    check("active", {31'h0, pp_active_out}, 32'h0);
    $display("test reset values done");

    cw(8'h60, 8'hFF);
    cr(8'h60, 8'h07);
    cw(8'h60, 8'h02);
    cw(8'h61, 8'hFF);
    cr(8'h61, 8'hFC);
    cw(8'h61, 8'h78);
    cw(8'h71, 8'hFF);
    cr(8'h71, 8'h02);
    cw(8'h71, 8'h00);
    cr(8'h71, 8'h00);
    cw(8'h75, 8'h00);
    cr(8'h75, 8'h04);
    xfer(1'b1, ca(8'h31), 8'h5A, 8'h00, 1'b1);
    xfer(1'b0, ca(8'h31), 8'h00, 8'h00, 1'b1);
    xfer(1'b0, 20'h80000, 8'h00, 8'h00, 1'b1);
    d = $random(seed);
    cw(8'h70, d);
    cw(8'h71, 8'h02);
    idle(2);
    check("irq_select", {24'h0, irq_select_out}, {24'h0, d});
    $display("test masks done");

    cw(8'h30, 8'h01);
    idle(3);
    check("active gated", {31'h0, pp_active_out}, 32'h0);
    global_cfg_enable_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    check("active", {31'h0, pp_active_out}, 32'h1);
    $display("test activation done");

    for (int m = 0; m < 8; m++) begin
      mode(m[2:0]);
      rr(RT_MODE, {m[2:0], 5'h00});
      idle(2);
      check("mode", {29'h0, pp_mode_out}, m);
    end
    st = $random(seed);
    port_status_in <= st;
    mode(MD_STD);
    d = $random(seed);
    rw(RT_DATA, d);
    rr(RT_DATA, d);
    rw(RT_CONTROL, ~d);
    rr(RT_CONTROL, ~d);
    rr(RT_STATUS, st);
    rw(RT_EPP_ADDR, 8'h3C);
    rr(RT_EPP_ADDR, 8'h00);
    idle(2);
    check("data latch", {24'h0, pp_data_out}, {24'h0, d});
    check("control", {24'h0, pp_control_out}, {24'h0, ~d});
    mode(MD_EPP);
    for (int k = 0; k < 8; k++) begin
      if (k == 1 || k == 2) continue;
      d = $random(seed);
      rw(k[15:0], d);
      rr(k[15:0], d);
    end
    rr(RT_STATUS, st);
    mode(MD_CAP);
    rr(RT_FIFO, 8'h10);
    rr(RT_CAP_B, 8'h00);
    for (int m = 2; m < 7; m++) begin
      if (m == 4 || m == 5) continue;
      mode(m[2:0]);
      idle(1);
      st = push_n;
      d = $random(seed);
      rw(RT_FIFO, d);
      idle(2);
      check("queue push", push_n, st + 1);
      check("queue byte", {24'h0, fifo_data_out}, {24'h0, d});
      rr(RT_FIFO, (m == 2) ? 8'h00 : d);
      if (m == 3) begin
        rw(RT_DATA, 8'h3A);
        idle(2);
        check("address queue", {24'h0, fifo_data_out}, 32'h3A);
      end
    end
    $display("test runtime map done");

    mode(MD_ECP);
    cr(8'h71, 8'h03);
    idle(2);
    check("irq level", {31'h0, irq_level_out}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      rw(RT_EXT_INDEX, xi[i]);
      rw(RT_EXT_DATA, 8'hA0 + i);
      rr(RT_EXT_DATA, 8'hA0 + i);
    end
    rw(RT_EXT_AUX, 8'h5C);
    rr(RT_EXT_AUX, 8'h5C);
    rw(RT_EXT_INDEX, 8'h01);
    rw(RT_EXT_DATA, 8'h77);
    rr(RT_EXT_DATA, 8'h00);
    rr(RT_EXT_INDEX, 8'h01);
    cw(8'hF0, 8'hE2);
    rr(RT_EXT_INDEX, 8'h00);
    rw(RT_EXT_INDEX, 8'h05);
    rw(RT_EXT_DATA, 8'h11);
    cw(8'hF0, 8'hF2);
    rr(RT_EXT_INDEX, 8'h01);
    rw(RT_EXT_INDEX, 8'h05);
    rr(RT_EXT_DATA, 8'hA3);
    mode(MD_STD);
    rr(RT_EXT_DATA, 8'hA3);
    mode(MD_EPP);
    rr(RT_EXT_DATA, 8'h00);
    cr(8'h71, 8'h02);
    idle(2);
    check("irq level", {31'h0, irq_level_out}, 32'h0);
    $display("test extended registers done");
    idle(3);
    check("notes left", exp_q.size(), 0);
    end_of_test();
  end
endmodule
`default_nettype wire
